// ---- logic/csp_pkg.sv ----
// Purpose: Shared constants and types for the clocked serial 8-bit port.
// Assumes: Register index times four gives the AXI4-Lite byte address.
// Notes:   Index values above 6'h2f are locally assigned control words.
package csp_pkg;
	localparam int unsigned ADDR_W        = 8;
	localparam int unsigned DATA_W        = 32;
	// Register indices.
	localparam logic [5:0]  IDX_PORT_FUNC = 6'h0b;
	localparam logic [5:0]  IDX_CLK_GATE  = 6'h0e;
	localparam logic [5:0]  IDX_CLK_SEL   = 6'h24;
	localparam logic [5:0]  IDX_IDLE      = 6'h25;
	localparam logic [5:0]  IDX_SHIFT_LO  = 6'h26;
	localparam logic [5:0]  IDX_SHIFT_HI  = 6'h27;
	localparam logic [5:0]  IDX_CTRL      = 6'h30;
	localparam logic [5:0]  IDX_STATUS    = 6'h31;
	// Reset values.
	localparam logic [3:0]  CLK_SEL_RST   = 4'h0;
	localparam logic [3:0]  PORT_FUNC_RST = 4'h0;
	localparam logic [7:0]  SHIFT_RST     = 8'h00;
	localparam logic        IDLE_RST      = 1'b1;
	// Field positions.
	localparam int unsigned PF_SHIFT_EN   = 3;
	localparam int unsigned PF_SO_EN      = 2;
	localparam int unsigned PF_SCK_EN     = 1;
	localparam int unsigned IDLE_LVL_BIT  = 1;
	localparam int unsigned CTRL_START    = 0;
	localparam int unsigned STAT_FLAG     = 0;
	// Clock source codes and counts.
	localparam logic [2:0]  SEL_EXT       = 3'h7;
	localparam logic [2:0]  SEL_SYS       = 3'h6;
	localparam logic [4:0]  SEL_SHIFT_TOP = 5'h0c;
	localparam logic [2:0]  CNT_CLR       = 3'h0;
	localparam logic [2:0]  CNT_LAST      = 3'h7;
	localparam logic [1:0]  SEL_DELAY     = 2'h2;
	localparam logic [19:0] HALF_MIN      = 20'h00001;
	// AXI responses.
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	typedef enum logic [1:0] {
		CSP_WAIT_START,
		CSP_WAIT_CLK,
		CSP_XFER,
		CSP_CONT
	} csp_state_t;
endpackage

// ---- logic/csp_serial_port.sv ----
// Purpose: Clock-synchronous 8-bit serial port with AXI4-Lite registers.
// Assumes: One bus write equals one instruction for mode-change latency.
// Notes:   Pins are split into input, output and active-low output enable.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
module csp_serial_port #(
	parameter int unsigned TCYC_CLKS = 4
) (
	// Clock and reset.
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// AXI4-Lite write address.
	input  wire logic [csp_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	// AXI4-Lite write data.
	input  wire logic [csp_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [csp_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [csp_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Serial clock pin.
	input  wire logic                        sck_in,
	output logic                             sck_out,
	output logic                             sck_oe_n,
	// Serial data pins.
	input  wire logic                        si_in,
	output logic                             so_out,
	output logic                             so_oe_n,
	// Transfer end flag.
	output logic                             serial_irq_flag
);
	import csp_pkg::*;

	csp_state_t                state_r;
	logic                      aw_held_r;
	logic                      w_held_r;
	logic [ADDR_W-1:0]         awaddr_r;
	logic [DATA_W-1:0]         wdata_r;
	logic                      wstrb_r;
	logic                      bvalid_r;
	logic                      rvalid_r;
	logic [DATA_W-1:0]         rdata_r;
	logic [1:0]                rresp_r;
	logic [1:0]                bresp_r;
	logic [3:0]                port_func_r;
	logic [3:0]                sel_pend_r;
	logic [3:0]                sel_eff_r;
	logic [1:0]                sel_dly_r;
	logic [7:0]                shift_r;
	logic [2:0]                bit_counter_r;
	logic                      flag_r;
	logic                      first_low_r;
	logic                      so_r;
	logic                      sck_gen_r;
	logic [19:0]               div_r;
	logic                      sck_s1_r;
	logic                      sck_s2_r;
	logic                      sck_s3_r;
	logic                      si_s1_r;
	logic                      si_s2_r;
	logic [19:0]               half_nxt;
	logic [4:0]                sh;
	logic [DATA_W-1:0]         rd_mux;
	logic                      rd_hit;
	wire                       wr_en = aw_held_r && w_held_r && !bvalid_r;
	wire [5:0]                 wr_idx = awaddr_r[7:2];
	wire                       wr_ok = wr_en && wstrb_r;
	wire                       serial_clock_select_wr = wr_ok && (wr_idx == IDX_CLK_SEL);
	wire                       start_wr = wr_ok && (wr_idx == IDX_CTRL) && wdata_r[CTRL_START];
	wire                       clr_wr = wr_ok && (wr_idx == IDX_STATUS) && wdata_r[STAT_FLAG];
	wire                       int_mode = (sel_eff_r[2:0] != SEL_EXT);
	wire                       mode_cont = !port_func_r[PF_SHIFT_EN] && port_func_r[PF_SCK_EN];
	wire                       mode_tx = port_func_r[PF_SHIFT_EN] && port_func_r[PF_SO_EN]
		&& port_func_r[PF_SCK_EN];
	wire                       gen_run = int_mode && (state_r != CSP_WAIT_START);
	wire                       gen_tog = gen_run && (div_r >= half_nxt - HALF_MIN);
	wire                       sck_fall = int_mode ? (gen_tog && sck_gen_r) : (sck_s3_r && !sck_s2_r);
	wire                       sck_rise = int_mode ? (gen_tog && !sck_gen_r) : (!sck_s3_r && sck_s2_r);
	wire                       in_xfer = (state_r == CSP_XFER);
	wire                       cnt_last = (bit_counter_r == CNT_LAST);
	wire                       enter_xfer = (state_r == CSP_WAIT_CLK) && sck_fall && !serial_clock_select_wr
		&& !start_wr && !(int_mode && mode_cont);
	wire                       leave_xfer = in_xfer && (serial_clock_select_wr || start_wr || (sck_rise && cnt_last));
	// AXI4-Lite slave handshakes and serial pin outputs.
	assign s_axi_awready   = !aw_held_r && !bvalid_r;
	assign s_axi_wready    = !w_held_r && !bvalid_r;
	assign s_axi_arready   = !rvalid_r;
	assign s_axi_bvalid    = bvalid_r;
	assign s_axi_bresp     = bresp_r;
	assign s_axi_rvalid    = rvalid_r;
	assign s_axi_rdata     = rdata_r;
	assign s_axi_rresp     = rresp_r;
	assign serial_irq_flag = flag_r;
	assign so_out          = so_r;
	assign so_oe_n         = !mode_tx;
	assign sck_out         = sck_gen_r;
	assign sck_oe_n        = !int_mode;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= '0;
			wstrb_r   <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb[0];
			end
			if (wr_en)
			begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= (wr_idx inside {IDX_PORT_FUNC, IDX_CLK_GATE, IDX_CLK_SEL, IDX_IDLE,
					IDX_SHIFT_LO, IDX_SHIFT_HI, IDX_CTRL, IDX_STATUS}) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_r && s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end
	always_comb
	begin
		rd_hit = 1'b1;
		rd_mux = '0;
		case (s_axi_araddr[7:2])
			IDX_SHIFT_LO: rd_mux[3:0] = shift_r[3:0];
			IDX_SHIFT_HI: rd_mux[3:0] = shift_r[7:4];
			IDX_STATUS:   rd_mux[3:0] = {(int_mode ? sck_gen_r : sck_s2_r), state_r, flag_r};
			IDX_PORT_FUNC, IDX_CLK_GATE, IDX_CLK_SEL, IDX_IDLE, IDX_CTRL: rd_mux = '0;
			default:      rd_hit = 1'b0;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_r <= 1'b0;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			port_func_r <= PORT_FUNC_RST;
		else if (wr_ok && (wr_idx == IDX_PORT_FUNC))
			port_func_r <= wdata_r[3:0];
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sel_pend_r <= CLK_SEL_RST;
			sel_eff_r  <= CLK_SEL_RST;
			sel_dly_r  <= 2'h0;
		end
		else if (serial_clock_select_wr)
		begin
			sel_pend_r <= wdata_r[3:0];
			sel_dly_r  <= SEL_DELAY - 2'h1;
		end
		else if (sel_dly_r != 2'h0)
		begin
			sel_dly_r <= sel_dly_r - 2'h1;
			if (sel_dly_r == 2'h1)
				sel_eff_r <= sel_pend_r;
		end
	end
	always_comb
	begin
		sh = (sel_eff_r[2:0] == SEL_SYS) ? 5'h00 : (SEL_SHIFT_TOP - {1'b0, sel_eff_r[2:0], 1'b0});
		sh = sh + {4'h0, sel_eff_r[3]};
		half_nxt = (20'(TCYC_CLKS) << sh) >> 1;
		if (half_nxt == 20'h0)
			half_nxt = HALF_MIN;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !gen_run || serial_clock_select_wr)
		begin
			sck_gen_r <= 1'b1;
			div_r     <= 20'h0;
		end
		else if (gen_tog)
		begin
			sck_gen_r <= !sck_gen_r;
			div_r     <= 20'h0;
		end
		else
			div_r <= div_r + 20'h1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sck_s1_r <= 1'b1;
			sck_s2_r <= 1'b1;
			sck_s3_r <= 1'b1;
			si_s1_r  <= 1'b0;
			si_s2_r  <= 1'b0;
		end
		else
		begin
			sck_s1_r <= sck_in;
			sck_s2_r <= sck_s1_r;
			sck_s3_r <= sck_s2_r;
			si_s1_r  <= si_in;
			si_s2_r  <= si_s1_r;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_r <= CSP_WAIT_START;
		else if (serial_clock_select_wr)
			state_r <= CSP_WAIT_START;
		else
			case (state_r)
				CSP_WAIT_START: if (start_wr)
					state_r <= CSP_WAIT_CLK;
				CSP_WAIT_CLK: if (!start_wr && sck_fall)
					state_r <= (int_mode && mode_cont) ? CSP_CONT : CSP_XFER;
				CSP_XFER: if (start_wr)
					state_r <= CSP_WAIT_CLK;
				else if (sck_rise && cnt_last)
					state_r <= int_mode ? CSP_WAIT_START : CSP_WAIT_CLK;
				CSP_CONT: state_r <= CSP_CONT;
				default: state_r <= CSP_WAIT_START;
			endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn || serial_clock_select_wr || start_wr || leave_xfer)
			bit_counter_r <= CNT_CLR;
		else if (in_xfer && sck_rise)
			bit_counter_r <= bit_counter_r + 3'h1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			first_low_r <= 1'b0;
		else if (enter_xfer)
			first_low_r <= 1'b1;
		else if (sck_rise || leave_xfer)
			first_low_r <= 1'b0;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flag_r <= 1'b0;
		else if (leave_xfer && !first_low_r)
			flag_r <= 1'b1;
		else if (clr_wr)
			flag_r <= 1'b0;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			shift_r <= SHIFT_RST;
		else if (wr_ok && (wr_idx == IDX_SHIFT_LO))
			shift_r[3:0] <= wdata_r[3:0];
		else if (wr_ok && (wr_idx == IDX_SHIFT_HI))
			shift_r[7:4] <= wdata_r[3:0];
		else if (in_xfer && sck_rise && !serial_clock_select_wr && !start_wr && port_func_r[PF_SHIFT_EN])
			shift_r <= {si_s2_r, shift_r[7:1]};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			so_r <= IDLE_RST;
		else if (wr_ok && (wr_idx == IDX_IDLE) && !in_xfer)
			so_r <= wdata_r[IDLE_LVL_BIT];
		else if ((enter_xfer || (in_xfer && sck_fall && !serial_clock_select_wr && !start_wr))
			&& port_func_r[PF_SHIFT_EN])
			so_r <= shift_r[0];
	end

	cnt_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		start_wr |=> bit_counter_r == CNT_CLR)
		else $error("bit counter not cleared by start");
	start_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_r == CSP_WAIT_START && !start_wr |=> state_r == CSP_WAIT_START
		&& bit_counter_r == CNT_CLR)
		else $error("start-wait left without start");
	start_move_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_r == CSP_WAIT_START && start_wr && !serial_clock_select_wr |=> state_r == CSP_WAIT_CLK)
		else $error("start did not reach clock-wait");
	fall_enter_a: assert property (@(posedge aclk) disable iff (!aresetn)
		enter_xfer |=> in_xfer ##0 first_low_r)
		else $error("first fall did not enter transfer");
	serial_clock_select_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
		serial_clock_select_wr |=> state_r == CSP_WAIT_START && bit_counter_r == CNT_CLR)
		else $error("clock select write did not initialize");
	done_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		in_xfer && sck_rise && cnt_last && !serial_clock_select_wr && !start_wr |=> flag_r
		&& (state_r == (int_mode ? CSP_WAIT_START : CSP_WAIT_CLK)))
		else $error("eighth clock did not end transfer");
	first_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!flag_r && first_low_r && leave_xfer |=> !flag_r)
		else $error("flag set in first low interval");
	sel_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
		serial_clock_select_wr ##1 !serial_clock_select_wr |-> ##1 sel_eff_r == $past(sel_pend_r))
		else $error("clock select latency wrong");
	idle_so_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ok && wr_idx == IDX_IDLE && !in_xfer |=> so_out == $past(wdata_r[IDLE_LVL_BIT]))
		else $error("idle level not on data-out");
	lsb_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		in_xfer && sck_fall && !serial_clock_select_wr && !start_wr && port_func_r[PF_SHIFT_EN]
		&& !(wr_ok && wr_idx == IDX_IDLE) |=> so_out == $past(shift_r[0]))
		else $error("transmit bit order wrong");
endmodule

// ---- verif/csp_serial_partner.sv ----
// Purpose: External clock-synchronous serial device facing the port.
// Assumes: Half period of its serial clock is 62.5 ns (125 ns period).
// Notes:   Clock stands high outside frames unless level parks it low; data line toggles when released.
`timescale 1ns/100ps
module csp_serial_partner (
	// Serial clock the device drives.
	output logic       sck_drv,
	// Serial data lines.
	output logic       si_drv,
	input  wire logic  so_line,
	// Byte collected from the port.
	output logic [7:0] rx_byte
);
	initial
	begin
		sck_drv <= 1'b1;
		si_drv  <= 1'b0;
		rx_byte <= 8'h00;
	end

	// LSB first, change on fall, sample on rise.
	task automatic frame(input int n, input logic [7:0] tx);
		for (int i = 0; i < n; i++)
		begin
			sck_drv <= 1'b0;
			si_drv  <= tx[i % 8];
			#62.5;
			sck_drv <= 1'b1;
			rx_byte <= {so_line, rx_byte[7:1]};
			#62.5;
		end
		si_drv <= ~si_drv;
	endtask

	// Parks the clock pin at one level outside a frame.
	task automatic level(input logic v);
		sck_drv <= v;
	endtask
endmodule

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the clocked serial 8-bit port.
// Assumes: TCYC_CLKS is 1 so internal clocks run fast.
// Notes:   Registers are reached through AXI4-Lite tasks only.
`timescale 1ns/100ps
module tb_top;
	import csp_pkg::*;
	logic              aclk;
	logic              aresetn;
	logic [ADDR_W-1:0] awaddr;
	logic              awvalid;
	logic              awready;
	logic [DATA_W-1:0] wdata;
	logic              wvalid;
	logic              wready;
	logic [1:0]        bresp;
	logic              bvalid;
	logic              bready;
	logic [ADDR_W-1:0] araddr;
	logic              arvalid;
	logic              arready;
	logic [DATA_W-1:0] rdata;
	logic [1:0]        rresp;
	logic              rvalid;
	logic              rready;
	logic              sck_out;
	logic              sck_oe_n;
	logic              sck_drv;
	logic              sck_line;
	logic              si_drv;
	logic              so_out;
	logic              so_oe_n;
	logic              flag;
	logic [7:0]        rx_byte;
	logic [31:0]       d;
	logic [1:0]        resp;
	logic [3:0]        modes [3] = '{4'h2, 4'h8, 4'he};
	int                error_cnt;
	int                comparisons;

	assign sck_line = sck_oe_n ? sck_drv : sck_out;

	csp_serial_port #(.TCYC_CLKS(1)) u_csp_serial_port (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sck_in(sck_line), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
		.si_in(si_drv), .so_out(so_out), .so_oe_n(so_oe_n), .serial_irq_flag(flag)
	);

	csp_serial_partner u_csp_serial_partner (
		.sck_drv(sck_drv), .si_drv(si_drv), .so_line(so_out), .rx_byte(rx_byte)
	);

	initial
	begin
		aclk = 1'b0;
	end
	always #5 aclk = ~aclk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			error_cnt++;
		end
	endtask

	task automatic axi_wr(input logic [5:0] idx, input logic [3:0] val);
		logic a_ok, w_ok, a_done, w_done, b_ok;
		a_done = 1'b0;
		w_done = 1'b0;
		b_ok   = 1'b0;
		@(posedge aclk);
		awaddr  <= {idx, 2'b00};
		wdata   <= {28'h0000000, val};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(a_done && w_done))
		begin
			@(negedge aclk);
			a_ok = awready && !a_done;
			w_ok = wready && !w_done;
			@(posedge aclk);
			if (a_ok) awvalid <= 1'b0;
			if (w_ok) wvalid <= 1'b0;
			a_done = a_done || a_ok;
			w_done = w_done || w_ok;
		end
		while (!b_ok)
		begin
			@(negedge aclk);
			b_ok = (bvalid === 1'b1);
			resp = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [5:0] idx);
		logic ok;
		ok = 1'b0;
		@(posedge aclk);
		araddr  <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!ok)
		begin
			@(negedge aclk);
			ok = (arready === 1'b1);
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		ok = 1'b0;
		while (!ok)
		begin
			@(negedge aclk);
			ok   = (rvalid === 1'b1);
			d    = rdata;
			resp = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
	endtask

	// Status bits: flag in bit 0, state in bits 2:1.
	task automatic chk_stat(input logic [2:0] exp);
		axi_rd(IDX_STATUS);
		check({29'h0, d[2:0]}, {29'h0, exp});
	endtask

	task automatic wait_flag();
		d = 32'h0;
		for (int i = 0; i < 100 && d[STAT_FLAG] !== 1'b1; i++) axi_rd(IDX_STATUS);
		check({31'h0, d[STAT_FLAG]}, 32'h1);
	endtask

	task automatic set_mode(input logic [3:0] sel, input logic [3:0] pf);
		axi_wr(IDX_STATUS, 4'h1);
		axi_wr(IDX_PORT_FUNC, pf);
		axi_wr(IDX_CLK_SEL, sel);
		repeat (3) @(posedge aclk);
	endtask

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		#500us;
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		aresetn = 1'b0;
		{awaddr, wdata, araddr} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		chk_stat(3'h0);
		axi_rd(6'h3f);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		axi_wr(6'h3f, 4'h1);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		foreach (modes[i])
		begin
			axi_wr(IDX_PORT_FUNC, modes[i]);
			check({31'h0, so_oe_n}, {31'h0, modes[i] != 4'he});
		end
		axi_wr(IDX_IDLE, 4'h0);
		check({30'h0, resp}, {30'h0, RESP_OKAY});
		@(posedge aclk);
		check({31'h0, so_out}, 32'h0);
		axi_wr(IDX_IDLE, 4'h2);
		@(posedge aclk);
		check({31'h0, so_out}, 32'h1);
		set_mode(4'h7, 4'he);
		check({31'h0, sck_oe_n}, 32'h1);
		axi_wr(IDX_SHIFT_LO, 4'h5);
		axi_wr(IDX_SHIFT_HI, 4'ha);
		axi_wr(IDX_CTRL, 4'h1);
		chk_stat(3'h2);
		u_csp_serial_partner.frame(8, 8'h3c);
		chk_stat(3'h3);
		check({24'h0, rx_byte}, 32'ha5);
		axi_rd(IDX_SHIFT_LO);
		check(d, 32'hc);
		axi_rd(IDX_SHIFT_HI);
		check(d, 32'h3);
		axi_wr(IDX_STATUS, 4'h1);
		u_csp_serial_partner.frame(10, 8'h00);
		chk_stat(3'h5);
		axi_wr(IDX_STATUS, 4'h1);
		axi_wr(IDX_CLK_SEL, 4'h7);
		chk_stat(3'h1);
		u_csp_serial_partner.frame(3, 8'h00);
		chk_stat(3'h1);
		axi_wr(IDX_STATUS, 4'h1);
		axi_wr(IDX_CTRL, 4'h1);
		u_csp_serial_partner.frame(3, 8'h00);
		axi_wr(IDX_CTRL, 4'h1);
		chk_stat(3'h3);
		axi_wr(IDX_CLK_SEL, 4'h7);
		chk_stat(3'h1);
		axi_wr(IDX_STATUS, 4'h1);
		axi_wr(IDX_CTRL, 4'h1);
		u_csp_serial_partner.level(1'b0);
		repeat (6) @(posedge aclk);
		axi_wr(IDX_CTRL, 4'h1);
		chk_stat(3'h2);
		u_csp_serial_partner.level(1'b1);
		set_mode(4'h6, 4'he);
		axi_wr(IDX_CTRL, 4'h1);
		wait_flag();
		check({31'h0, flag}, 32'h1);
		chk_stat(3'h1);
		check({31'h0, sck_out}, 32'h1);
		set_mode(4'h6, 4'h2);
		check({31'h0, sck_oe_n}, 32'h0);
		axi_wr(IDX_CTRL, 4'h1);
		repeat (20) @(posedge aclk);
		@(negedge aclk);
		d[0] = sck_out;
		@(negedge aclk);
		check({31'h0, sck_out}, {31'h0, ~d[0]});
		chk_stat(3'h6);
		axi_wr(IDX_CLK_SEL, 4'h6);
		chk_stat(3'h0);
		give_verdict();
	end
endmodule
